// ---- tsf_temperature_sample_fifo.sv ----
// What this block does
// R1: write index is 5 bits, steps once per stored sample, wraps 0x1F to 0x00.
// R2: read index is 5 bits, steps once per word read, wraps 0x1F to 0x00.
// R3: master may read and write the read index to refetch a word.
// R4: count words lost on pushes into a full queue, saturating at 0x1F.
// R5: lost count returns to zero whenever one whole word is popped.
// R6: read-only 6-bit unread count, up per stored sample, down per read word.
// R7: data port is read-only; 2N byte reads deliver N words, index up by N.
// R8: each word gives its upper byte first, then its lower byte.
// R9: empty and full both leave the indices equal unless the read index was written since the last flush; the count tells them apart.
// R10: almost-full sets once count reaches 32 minus the watermark.
// R11: almost-full drives pin0 interrupt only if enabled and pin0 mode is 0x3.
// R12: rollover on and queue full: new sample overwrites the oldest.
// R13: rollover off and queue full: new sample dropped, contents unchanged.
// R14: type 0: status read clears flag; every new sample re-sets it if still met.
// R15: type 1: flag sets only on fresh entry into the almost-full condition.
// R16: clear option 0: data reads leave the flag, only status read clears.
// R17: clear option 1: data read or status read clears the flag.
// R18: flush empties queue, zeroes both indices and both counts, self-clears.
// R19: master should treat 32 words as available when lost count is nonzero.
// R20: data read on an empty queue changes neither read index nor count.
`timescale 1ns/1ps
`default_nettype none

module tsf_sample_queue #(
  parameter int W = 16,
  parameter int DEPTH = 32
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic flush,
  input wire logic rollover_next,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [W-1:0] wr_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [W-1:0] rd_data,
  input wire logic rd_load,
  input wire logic [$clog2(DEPTH)-1:0] rd_load_idx,
  output logic [$clog2(DEPTH)-1:0] wr_idx,
  output logic [$clog2(DEPTH)-1:0] rd_idx,
  output logic [$clog2(DEPTH):0] count,
  output logic [$clog2(DEPTH)-1:0] lost
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LOST_SAT = {AW{1'b1}};

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
    logic [AW-1:0] lost;
    logic ro;
    logic ready;
  } tsf_queue_st_t;

  tsf_queue_st_t s;
  tsf_queue_st_t n;
  logic full;
  logic pop;
  logic store;
  logic overwrite;
  logic drop;

  // event decode
  assign full = (s.cnt == CNT_FULL); // R9
  assign pop = rd_ready && (s.cnt != '0); // R20
  assign store = wr_valid && (!full || pop || s.ro); // R12 R13
  assign overwrite = wr_valid && full && !pop && s.ro; // R12
  assign drop = wr_valid && full && !pop; // R4

  // next state
  always_comb begin
    n = s;
    if (store) begin
      n.mem[s.wr] = wr_data;
      n.wr = s.wr + 1'b1; // R1
    end
    if (pop || overwrite) begin
      n.rd = s.rd + 1'b1; // R2 R12
    end
    if (store && !pop && !overwrite) begin
      n.cnt = s.cnt + 1'b1; // R6
    end else if (pop && !store) begin
      n.cnt = s.cnt - 1'b1; // R6
    end
    if (pop) begin
      n.lost = '0; // R5
    end else if (drop && (s.lost != LOST_SAT)) begin
      n.lost = s.lost + 1'b1; // R4
    end
    if (rd_load) begin
      n.rd = rd_load_idx; // R3
    end
    if (flush) begin
      n.wr = '0; // R18
      n.rd = '0;
      n.cnt = '0;
      n.lost = '0;
    end
    n.ro = rollover_next;
    n.ready = (n.cnt != CNT_FULL) || rollover_next;
  end

  // state register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
      s.ready <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign wr_ready = s.ready;
  assign rd_valid = (s.cnt != '0);
  assign rd_data = s.mem[s.rd];
  assign wr_idx = s.wr;
  assign rd_idx = s.rd;
  assign count = s.cnt;
  assign lost = s.lost;
endmodule // tsf_sample_queue

module tsf_temperature_sample_fifo
  import tsf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire tsf_reg_req_t reg_req,
  output tsf_reg_rsp_t reg_rsp,
  input wire tsf_push_t push,
  output logic push_ready,
  input wire logic status_read,
  input wire logic a_full_en,
  input wire logic [1:0] pin0_mode_field,
  output logic a_full_flag,
  output logic general_pin0_irq
);
  typedef struct packed {
    tsf_reg_rsp_t rsp;
    logic [TSF_IDX_W-1:0] wm;
    logic stat_clr;
    logic af_type;
    logic ro;
    tsf_phase_t phase;
    logic cond;
    logic push_d;
    logic flag;
    logic irq;
    logic rd_touched;
  } tsf_top_st_t;

  tsf_top_st_t s;
  tsf_top_st_t n;
  logic data_rd;
  logic pop;
  logic rd_load;
  logic flush;
  logic cond;
  logic af_set;
  logic af_clr;
  logic [TSF_WORD_W-1:0] head;
  logic [TSF_IDX_W-1:0] wr_idx;
  logic [TSF_IDX_W-1:0] rd_idx;
  logic [TSF_CNT_W-1:0] count;
  logic [TSF_IDX_W-1:0] lost;

  // almost-full threshold is full minus watermark
  function automatic logic af_reached(input logic [TSF_CNT_W-1:0] cnt, input logic [TSF_IDX_W-1:0] wm);
    af_reached = (cnt >= (TSF_CNT_FULL - {1'b0, wm}));
  endfunction

  // register port decode
  assign data_rd = reg_req.rd && (reg_req.addr == TSF_OFS_DATA);
  assign pop = data_rd && (s.phase == TSF_PH_LOW); // R7 R8
  assign rd_load = reg_req.wr && (reg_req.addr == TSF_OFS_RD_IDX); // R3
  assign flush = reg_req.wr && (reg_req.addr == TSF_OFS_QCFG) && reg_req.wdata[TSF_BIT_FLUSH]; // R18

  // flag set and clear terms
  assign cond = af_reached(count, s.wm); // R10
  assign af_set = cond && (s.af_type ? !s.cond : (s.push_d || !s.cond)); // R14 R15
  assign af_clr = status_read || (s.stat_clr && data_rd); // R16 R17

  tsf_sample_queue #(
    .W(TSF_WORD_W),
    .DEPTH(TSF_DEPTH)
  ) u_queue (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .flush(flush),
    .rollover_next(n.ro),
    .wr_valid(push.valid),
    .wr_ready(push_ready),
    .wr_data(push.data),
    .rd_valid(),
    .rd_ready(pop),
    .rd_data(head),
    .rd_load(rd_load),
    .rd_load_idx(reg_req.wdata[TSF_IDX_W-1:0]),
    .wr_idx(wr_idx),
    .rd_idx(rd_idx),
    .count(count),
    .lost(lost)
  );

  // next state: register file, byte phase, flag and interrupt
  always_comb begin
    n = s;
    n.rsp.valid = 1'b0;
    if (data_rd) begin
      n.phase = (s.phase == TSF_PH_HIGH) ? TSF_PH_LOW : TSF_PH_HIGH; // R8
    end
    if (rd_load || flush) begin
      n.phase = TSF_PH_HIGH;
    end
    if (reg_req.rd) begin
      n.rsp.valid = 1'b1;
      case (reg_req.addr)
        TSF_OFS_WR_IDX: n.rsp.data = {3'h0, wr_idx};
        TSF_OFS_RD_IDX: n.rsp.data = {3'h0, rd_idx};
        TSF_OFS_LOST: n.rsp.data = {3'h0, lost};
        TSF_OFS_COUNT: n.rsp.data = {2'h0, count};
        TSF_OFS_DATA: n.rsp.data = (s.phase == TSF_PH_HIGH) ? head[15:8] : head[7:0]; // R8
        TSF_OFS_WM: n.rsp.data = {3'h0, s.wm};
        TSF_OFS_QCFG: n.rsp.data = {4'h0, s.stat_clr, s.af_type, s.ro, 1'b0};
        default: n.rsp.data = TSF_RD_UNMAPPED;
      endcase
    end
    if (reg_req.wr && (reg_req.addr == TSF_OFS_WM)) begin
      n.wm = reg_req.wdata[TSF_IDX_W-1:0];
    end
    if (reg_req.wr && (reg_req.addr == TSF_OFS_QCFG)) begin
      n.stat_clr = reg_req.wdata[TSF_BIT_STAT_CLR];
      n.af_type = reg_req.wdata[TSF_BIT_AF_TYPE];
      n.ro = reg_req.wdata[TSF_BIT_RO];
    end
    n.cond = cond;
    n.push_d = push.valid;
    // set wins over clear
    if (af_set) begin
      n.flag = 1'b1;
    end else if (af_clr) begin
      n.flag = 1'b0;
    end
    n.irq = n.flag && a_full_en && (pin0_mode_field == TSF_PIN_MODE_IRQ); // R11
    if (rd_load) begin
      n.rd_touched = 1'b1;
    end
    if (flush) begin
      n.rd_touched = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
      s.wm <= TSF_WM_RST;
      s.phase <= TSF_PH_HIGH;
    end else begin
      s <= n;
    end
  end

  assign reg_rsp = s.rsp;
  assign a_full_flag = s.flag;
  assign general_pin0_irq = s.irq;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // accepted push advances the write index by one, with wrap
  property p_wr_step;
    push.valid && push_ready && !flush |=> wr_idx == $past(wr_idx) + 5'h01;
  endproperty
  a_wr_step: assert property (p_wr_step) else $error("write index did not step"); // R1

  // popped word advances the read index by one
  property p_rd_step;
    pop && (count != '0) && !rd_load && !flush |=> rd_idx == $past(rd_idx) + 5'h01;
  endproperty
  a_rd_step: assert property (p_rd_step) else $error("read index did not step"); // R2 R7

  // written read index is taken
  property p_rd_load;
    rd_load |=> rd_idx == $past(reg_req.wdata[TSF_IDX_W-1:0]);
  endproperty
  a_rd_load: assert property (p_rd_load) else $error("read index write lost"); // R3

  // saturated lost count holds without a pop
  property p_lost_sat;
    lost == TSF_LOST_MAX && !pop && !flush |=> lost == TSF_LOST_MAX;
  endproperty
  a_lost_sat: assert property (p_lost_sat) else $error("lost count left saturation"); // R4

  // whole-word pop clears the lost count
  property p_lost_clr;
    pop && (count != '0) |=> lost == '0;
  endproperty
  a_lost_clr: assert property (p_lost_clr) else $error("lost count not cleared"); // R5

  // pop without push lowers the count by one
  property p_cnt_dn;
    pop && (count != '0) && !push.valid && !flush |=> count == $past(count) - 6'h01;
  endproperty
  a_cnt_dn: assert property (p_cnt_dn) else $error("count did not decrement"); // R6

  // upper byte first, lower byte on the next read
  property p_byte_order;
    data_rd && s.phase == TSF_PH_HIGH ##1 data_rd && !push.valid
      |=> reg_rsp.data == $past(head[7:0]) && $past(reg_rsp.data, 1) == $past(head[15:8], 2);
  endproperty
  a_byte_order: assert property (p_byte_order) else $error("byte order wrong"); // R8

  // empty or full means equal indices while the master leaves the index alone
  property p_idx_eq;
    !s.rd_touched && (count == '0 || count == TSF_CNT_FULL) |-> wr_idx == rd_idx;
  endproperty
  a_idx_eq: assert property (p_idx_eq) else $error("indices differ at empty or full"); // R9

  // interrupt only with the flag, enable and irq mode
  property p_irq;
    general_pin0_irq |-> a_full_flag && $past(a_full_en) && $past(pin0_mode_field) == TSF_PIN_MODE_IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("pin0 interrupt without cause"); // R11

  // rollover on a full queue keeps it full and drops the oldest
  property p_rollover;
    push.valid && count == TSF_CNT_FULL && s.ro && !pop && !flush && !rd_load
      |=> count == TSF_CNT_FULL && rd_idx == $past(rd_idx) + 5'h01;
  endproperty
  a_rollover: assert property (p_rollover) else $error("rollover did not overwrite"); // R12

  // discard on a full queue leaves the write index
  property p_discard;
    push.valid && !push_ready && !pop && !flush |=> $stable(wr_idx) && count == TSF_CNT_FULL;
  endproperty
  a_discard: assert property (p_discard) else $error("full queue changed on discard"); // R13

  // status read with no new set clears the flag
  property p_status_clr;
    status_read && !af_set |=> !a_full_flag;
  endproperty
  a_status_clr: assert property (p_status_clr) else $error("status read did not clear flag"); // R14 R15

  // data reads keep the flag when the clear option is off
  property p_keep_flag;
    a_full_flag && data_rd && !s.stat_clr && !status_read |=> a_full_flag;
  endproperty
  a_keep_flag: assert property (p_keep_flag) else $error("data read cleared flag"); // R16

  // data read clears the flag when the clear option is on
  property p_data_clr;
    data_rd && s.stat_clr && !af_set |=> !a_full_flag;
  endproperty
  a_data_clr: assert property (p_data_clr) else $error("data read kept flag"); // R17

  // flush zeroes indices and counts
  property p_flush;
    flush |=> wr_idx == '0 && rd_idx == '0 && count == '0 && lost == '0;
  endproperty
  a_flush: assert property (p_flush) else $error("flush incomplete"); // R18

  // empty data read leaves index and count
  property p_empty_rd;
    data_rd && count == '0 && !push.valid && !rd_load && !flush |=> $stable(rd_idx) && count == '0;
  endproperty
  a_empty_rd: assert property (p_empty_rd) else $error("empty read moved queue"); // R20

  // main scenarios
  property p_cov_flag;
    !a_full_flag ##1 a_full_flag;
  endproperty
  c_cov_flag: cover property (p_cov_flag);
  property p_cov_roll;
    push.valid && count == TSF_CNT_FULL && s.ro;
  endproperty
  c_cov_roll: cover property (p_cov_roll);
  property p_cov_drop;
    push.valid && !push_ready;
  endproperty
  c_cov_drop: cover property (p_cov_drop);
  property p_cov_flush;
    count != '0 ##1 flush;
  endproperty
  c_cov_flush: cover property (p_cov_flush);
endmodule // tsf_temperature_sample_fifo
`default_nettype wire

// ---- tsf_pkg.sv ----
`default_nettype none
package tsf_pkg;
  // fifo geometry
  localparam int TSF_DEPTH = 32;
  localparam int TSF_WORD_W = 16;
  localparam int TSF_IDX_W = 5;
  localparam int TSF_CNT_W = 6;
  localparam logic [TSF_CNT_W-1:0] TSF_CNT_FULL = 6'h20;
  localparam logic [TSF_IDX_W-1:0] TSF_LOST_MAX = 5'h1f;
  // register offsets
  localparam logic [7:0] TSF_OFS_WR_IDX = 8'h04;
  localparam logic [7:0] TSF_OFS_RD_IDX = 8'h05;
  localparam logic [7:0] TSF_OFS_LOST = 8'h06;
  localparam logic [7:0] TSF_OFS_COUNT = 8'h07;
  localparam logic [7:0] TSF_OFS_DATA = 8'h08;
  localparam logic [7:0] TSF_OFS_WM = 8'h09;
  localparam logic [7:0] TSF_OFS_QCFG = 8'h0a;
  localparam logic [7:0] TSF_RD_UNMAPPED = 8'h00;
  // queue_behaviour_config field positions
  localparam int TSF_BIT_FLUSH = 4;
  localparam int TSF_BIT_STAT_CLR = 3;
  localparam int TSF_BIT_AF_TYPE = 2;
  localparam int TSF_BIT_RO = 1;
  // reset values
  localparam logic [TSF_IDX_W-1:0] TSF_WM_RST = 5'h00;
  // pin0 mode that routes the almost-full interrupt
  localparam logic [1:0] TSF_PIN_MODE_IRQ = 2'h3;
  // byte phase of the data port
  typedef enum logic [1:0] {
    TSF_PH_HIGH = 2'b01,
    TSF_PH_LOW = 2'b10
  } tsf_phase_t;
  // register port request and answer
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tsf_reg_req_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } tsf_reg_rsp_t;
  // sample push from the conversion engine
  typedef struct packed {
    logic valid;
    logic [TSF_WORD_W-1:0] data;
  } tsf_push_t;
endpackage
`default_nettype wire

// ---- tsf_sample_source.sv ----
`timescale 1ns/1ps
`default_nettype none
// conversion engine stand-in: pushes n samples, one per cycle, after a go pulse
module tsf_sample_source
  import tsf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic go,
  input wire logic [5:0] n,
  output tsf_push_t push,
  output logic busy
);
  int left = 0;
  int id = 0;
  logic active = 1'b0;
  initial push = '0;
  // busy only changes on the edge itself, so the bench never races it
  assign busy = (left != 0) || active;
  // sample value is a fixed base plus a running id; idle data toggles so stale data never looks fresh
  always @(posedge clk_sys) begin
    if (go) begin
      left = n;
    end
    active = (left != 0);
    #1;
    if (left != 0) begin
      push.valid = 1'b1;
      push.data = 16'hc3a0 + id[15:0];
      id++;
      left--;
    end else begin
      push.valid = 1'b0;
      push.data = ~push.data;
    end
  end
endmodule // tsf_sample_source
`default_nettype wire

// ---- temperature_sample_fifo_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module temperature_sample_fifo_tb
  import tsf_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  tsf_reg_req_t reg_req = '0;
  tsf_reg_rsp_t reg_rsp;
  tsf_push_t push;
  logic push_ready;
  logic status_read = 1'b0;
  logic a_full_en = 1'b1;
  logic [1:0] pin0_mode_field = 2'h3;
  logic a_full_flag;
  logic general_pin0_irq;
  logic go = 1'b0;
  logic [5:0] src_n = 6'h00;
  logic src_busy;
  int errors = 0;
  int check_count = 0;

  always #20 clk_sys = ~clk_sys;

  tsf_temperature_sample_fifo DUT (.clk_sys(clk_sys), .rstn(rstn), .reg_req(reg_req), .reg_rsp(reg_rsp),
    .push(push), .push_ready(push_ready), .status_read(status_read), .a_full_en(a_full_en),
    .pin0_mode_field(pin0_mode_field), .a_full_flag(a_full_flag), .general_pin0_irq(general_pin0_irq));
  tsf_sample_source SRC (.clk_sys(clk_sys), .go(go), .n(src_n), .push(push), .busy(src_busy));

  task automatic report_and_stop();
    if (errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask
  // one read strobe; the answer is valid one cycle later
  task automatic rdx(input logic [7:0] a);
    step();
    reg_req.rd = 1'b1;
    reg_req.addr = a;
    step();
    reg_req.rd = 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    rdx(a);
    chk(reg_rsp.valid ? {8'h00, reg_rsp.data} : 16'hdead, {8'h00, e});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    step();
    reg_req.wr = 1'b1;
    reg_req.addr = a;
    reg_req.wdata = d;
    step();
    reg_req.wr = 1'b0;
  endtask
  // a word is two data-port reads, upper byte first
  task automatic word(input int id);
    logic [15:0] s;
    s = 16'hc3a0 + id[15:0];
    rdc(TSF_OFS_DATA, s[15:8]);
    rdc(TSF_OFS_DATA, s[7:0]);
  endtask
  task automatic pushes(input logic [5:0] n);
    step();
    go = 1'b1;
    src_n = n;
    step();
    go = 1'b0;
    for (int i = 0; i < 70 && src_busy; i++) begin
      step();
    end
    repeat (3) step();
  endtask
  task automatic stat();
    step();
    status_read = 1'b1;
    step();
    status_read = 1'b0;
    step();
    step();
  endtask
  task automatic flg(input logic ef, input logic ei);
    chk({14'h0, a_full_flag, general_pin0_irq}, {14'h0, ef, ei});
  endtask

  // watchdog well beyond the expected run length
  initial begin
    #200000;
    errors++;
    report_and_stop();
  end

  initial begin
    repeat (4) @(posedge clk_sys);
    #1;
    rstn = 1'b1;
    chk({15'h0, push_ready}, 16'h0001);
    for (int a = 4; a <= 10; a++) begin
      if (a != 8) begin
        rdc(a[7:0], 8'h00);
      end
    end
    rdc(8'h03, TSF_RD_UNMAPPED);
    pushes(6'd3);
    rdc(TSF_OFS_WR_IDX, 8'h03);
    rdc(TSF_OFS_COUNT, 8'h03);
    word(0);
    word(1);
    rdc(TSF_OFS_RD_IDX, 8'h02);
    rdc(TSF_OFS_COUNT, 8'h01);
    wr(TSF_OFS_RD_IDX, 8'h01);
    word(1);
    wr(TSF_OFS_WR_IDX, 8'h1f);
    rdc(TSF_OFS_WR_IDX, 8'h03);
    wr(TSF_OFS_QCFG, 8'h10);
    for (int a = 4; a <= 7; a++) begin
      rdc(a[7:0], 8'h00);
    end
    rdc(TSF_OFS_QCFG, 8'h00);
    rdx(TSF_OFS_DATA);
    rdx(TSF_OFS_DATA);
    rdc(TSF_OFS_RD_IDX, 8'h00);
    rdc(TSF_OFS_COUNT, 8'h00);
    // fill to 32 with rollover off: ids 3..34
    pushes(6'd32);
    rdc(TSF_OFS_COUNT, 8'h20);
    rdc(TSF_OFS_WR_IDX, 8'h00);
    rdc(TSF_OFS_RD_IDX, 8'h00);
    chk({15'h0, push_ready}, 16'h0000);
    flg(1'b1, 1'b1);
    pin0_mode_field = 2'h2;
    repeat (2) step();
    flg(1'b1, 1'b0);
    pin0_mode_field = 2'h3;
    a_full_en = 1'b0;
    repeat (2) step();
    flg(1'b1, 1'b0);
    a_full_en = 1'b1;
    pushes(6'd2);
    rdc(TSF_OFS_LOST, 8'h02);
    rdc(TSF_OFS_COUNT, 8'h20);
    word(3);
    rdc(TSF_OFS_LOST, 8'h00);
    flg(1'b1, 1'b1);
    // rollover on: second push overwrites the oldest word
    wr(TSF_OFS_QCFG, 8'h02);
    pushes(6'd2);
    word(5);
    rdc(TSF_OFS_COUNT, 8'h1f);
    stat();
    flg(1'b0, 1'b0);
    pushes(6'd1);
    flg(1'b1, 1'b1);
    stat();
    pushes(6'd1);
    flg(1'b1, 1'b1);
    wr(TSF_OFS_QCFG, 8'h06);
    stat();
    pushes(6'd1);
    flg(1'b0, 1'b0);
    wr(TSF_OFS_QCFG, 8'h0e);
    word(8);
    pushes(6'd1);
    flg(1'b1, 1'b1);
    rdx(TSF_OFS_DATA);
    repeat (2) step();
    flg(1'b0, 1'b0);
    // watermark 2 sets the flag at the thirtieth word
    wr(TSF_OFS_QCFG, 8'h10);
    wr(TSF_OFS_WM, 8'h02);
    rdc(TSF_OFS_WM, 8'h02);
    pushes(6'd29);
    flg(1'b0, 1'b0);
    pushes(6'd1);
    flg(1'b1, 1'b1);
    // keep pushing into the full queue: the lost count saturates and stored words stay put
    pushes(6'd40);
    rdc(TSF_OFS_LOST, 8'h1f);
    rdc(TSF_OFS_COUNT, 8'h20);
    word(43);
    rdc(TSF_OFS_LOST, 8'h00);
    report_and_stop();
  end
endmodule // temperature_sample_fifo_tb
`default_nettype wire
